// *** hdl/hrx_addr_filter.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "hrx_params.svh"

module hrx_addr_filter
	import hrx_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// Mode configuration
	input  wire logic [1:0] serial_engine_select,
	input  wire logic [1:0] hdlc_submode_field,
	input  wire logic       address_width_bit,
	input  wire logic [1:0] ppp_mode_field,
	input  wire logic       signalling7_enable,
	input  wire logic       address_forward_enable,
	// Address compare and mask values
	input  wire logic [7:0] high_compare_one,
	input  wire logic [7:0] high_compare_two,
	input  wire logic [7:0] low_compare_one,
	input  wire logic [7:0] low_compare_two,
	input  wire logic       response_indication_bit,
	input  wire logic [7:0] high_mask_one,
	input  wire logic [7:0] high_mask_two,
	input  wire logic [7:0] low_mask_one,
	input  wire logic [7:0] low_mask_two,
	// Received octets from the deframer
	input  wire logic       rx_valid,
	output logic            rx_ready,
	input  wire logic [7:0] rx_data,
	input  wire logic       rx_end,
	input  wire logic [7:0] rx_status,
	// Receive FIFO drain side
	output logic            fifo_valid,
	input  wire logic       fifo_ready,
	output logic      [7:0] fifo_data,
	// Mode and frame reporting
	output hrx_mode_t       mode_now,
	output logic            hdlc_engine_on,
	output logic            async_engine_on,
	output logic            bisync_engine_on,
	output logic            frame_auto,
	output logic            frame_command,
	output logic            frame_response,
	output logic            frame_accepted,
	output logic            frame_dropped
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	// Masked compare; a set mask bit forces a match
	function automatic logic byte_hit(input logic [7:0] rx, input logic [7:0] cmp,
		input logic [7:0] msk, input logic ign_cr);
		logic [7:0] ign;
		ign = msk;
		ign[`HRX_CR_BIT] = msk[`HRX_CR_BIT] | ign_cr;
		byte_hit = ((rx ^ cmp) & ~ign) == 8'h00;
	endfunction

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	wire       sel_hdlc = (serial_engine_select == `HRX_SEL_HDLC);
	hrx_mode_t mode_dec;

	assign hdlc_engine_on   = sel_hdlc;
	assign async_engine_on  = (serial_engine_select == `HRX_SEL_ASYNC);
	assign bisync_engine_on = (serial_engine_select == `HRX_SEL_BISYNC);

	always_comb begin
		mode_dec = HRX_MODE_OFF;
		if (sel_hdlc) begin
			case (hdlc_submode_field)
				`HRX_MDS_AUTO:  mode_dec = HRX_MODE_AUTO;
				`HRX_MDS_ADDR2: mode_dec = HRX_MODE_ADDR2;
				`HRX_MDS_ADDR10: begin
					if (address_width_bit)
						mode_dec = HRX_MODE_ADDR1;
					else if (ppp_mode_field == `HRX_PPP_BITSYNC)
						mode_dec = HRX_MODE_PPP_BIT;
					else if (ppp_mode_field == `HRX_PPP_OCTET)
						mode_dec = HRX_MODE_PPP_OCT;
					else if (ppp_mode_field == `HRX_PPP_ASYNC)
						mode_dec = HRX_MODE_PPP_ASY;
					else if (signalling7_enable)
						mode_dec = HRX_MODE_SS7;
					else
						mode_dec = HRX_MODE_ADDR0;
				end
				`HRX_MDS_XTRANS: mode_dec = address_width_bit ? HRX_MODE_XTRANS : HRX_MODE_OFF;
				default: mode_dec = HRX_MODE_OFF;
			endcase
		end
	end
	assign mode_now = mode_dec;

	// ----------------------------------------
	// Frame state
	// ----------------------------------------
	hrx_state_t st_reg;
	hrx_mode_t  fmode_reg;
	logic       two_reg;
	logic [7:0] a0_reg;
	logic [7:0] a1_reg;
	logic [1:0] acnt_reg;
	logic [1:0] fcnt_reg;
	logic [7:0] stat_reg;

	// Modes with address recognition; others pass whole frames
	wire m_auto  = (fmode_reg == HRX_MODE_AUTO);
	wire m_addr2 = (fmode_reg == HRX_MODE_ADDR2);
	wire m_addr1 = (fmode_reg == HRX_MODE_ADDR1);
	wire m_recog = m_auto || m_addr2 || m_addr1;
	wire [1:0] need = (m_addr1 || !two_reg) ? 2'h1 : 2'h2;
	// Address complete: the deciding cycle refuses octets so none is lost
	wire       addr_full = (acnt_reg == need);

	// High byte candidates: groups ignore C/R, compares per indication bit
	wire [7:0] hi_byte = a0_reg;
	wire [7:0] lo_byte = two_reg ? a1_reg : a0_reg;
	wire hi_grp   = byte_hit(hi_byte, `HRX_GROUP_A, `HRX_MASK_RESET, 1'b1)
	             || byte_hit(hi_byte, `HRX_GROUP_B, `HRX_MASK_RESET, 1'b1);
	wire hi_one   = byte_hit(hi_byte, high_compare_one, high_mask_one, response_indication_bit);
	wire hi_two   = byte_hit(hi_byte, high_compare_two, high_mask_two, response_indication_bit);
	wire lo_one   = byte_hit(lo_byte, low_compare_one, low_mask_one, 1'b0);
	wire lo_two   = byte_hit(lo_byte, low_compare_two, low_mask_two, 1'b0);
	wire hi_any   = hi_grp || hi_one || hi_two;

	// Acceptance per mode
	wire acc_addr1 = hi_any;
	wire acc_two   = hi_any && (lo_one || lo_two);
	wire acc_one   = lo_one || lo_two;
	wire accept    = m_addr1 ? acc_addr1 : (two_reg ? acc_two : acc_one);
	wire auto_hit  = m_auto && (two_reg ? (hi_one && lo_one) : lo_one);

	// Octets to replay once accepted: every address octet with the forward option, none without it
	wire [1:0] flush_n = m_addr1 ? (address_forward_enable ? 2'h1 : 2'h0)
	                   : (address_forward_enable ? need : 2'h0);

	// ----------------------------------------
	// FIFO feed
	// ----------------------------------------
	logic       push_v;
	logic [7:0] push_d;
	wire        push_rdy;
	wire        take;

	wire [7:0] flush_byte = (fcnt_reg == 2'h0) ? a0_reg : a1_reg;

	always_comb begin
		push_v   = 1'b0;
		push_d   = rx_data;
		rx_ready = 1'b0;
		case (st_reg)
			HRX_ST_IDLE, HRX_ST_DROP: rx_ready = 1'b1;
			HRX_ST_ADDR: rx_ready = !addr_full;
			HRX_ST_BODY: begin
				rx_ready = push_rdy;
				push_v   = rx_valid && !rx_end;
			end
			HRX_ST_FLUSH: begin
				push_v = 1'b1;
				push_d = flush_byte;
			end
			HRX_ST_STAT: begin
				push_v = 1'b1;
				push_d = stat_reg;
			end
			default: rx_ready = 1'b0;
		endcase
	end
	assign take = rx_valid && rx_ready;

	// First-octet view used before fmode_reg is loaded
	wire m_recog_new = (mode_dec == HRX_MODE_AUTO) || (mode_dec == HRX_MODE_ADDR2)
	                || (mode_dec == HRX_MODE_ADDR1);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg    <= HRX_ST_IDLE;
			fmode_reg <= HRX_MODE_OFF;
			two_reg   <= 1'b0;
			a0_reg    <= 8'h00;
			a1_reg    <= 8'h00;
			acnt_reg  <= 2'h0;
			fcnt_reg  <= 2'h0;
			stat_reg  <= 8'h00;
		end else begin
			case (st_reg)
				HRX_ST_IDLE: begin
					fcnt_reg <= 2'h0;
					acnt_reg <= 2'h0;
					if (take && !rx_end) begin
						fmode_reg <= mode_dec;
						two_reg   <= address_width_bit;
						a0_reg    <= rx_data;
						acnt_reg  <= 2'h1;
						st_reg    <= m_recog_new ? HRX_ST_ADDR : HRX_ST_FLUSH;
					end
				end
				HRX_ST_ADDR: begin
					if (!m_recog) begin
						st_reg <= HRX_ST_FLUSH;
					end else if (acnt_reg == need) begin
						if (accept)
							st_reg <= (flush_n == 2'h0) ? HRX_ST_BODY : HRX_ST_FLUSH;
						else
							st_reg <= HRX_ST_DROP;
					end else if (take) begin
						if (rx_end)
							st_reg <= HRX_ST_IDLE;
						else begin
							a1_reg   <= rx_data;
							acnt_reg <= acnt_reg + 2'h1;
						end
					end
				end
				HRX_ST_FLUSH: begin
					// Mode 0/transparent replays the first octet whole
					if (!m_recog) begin
						if (push_rdy)
							st_reg <= HRX_ST_BODY;
					end else if (m_addr1 && !address_forward_enable) begin
						st_reg <= HRX_ST_BODY;
					end else if (push_rdy) begin
						fcnt_reg <= fcnt_reg + 2'h1;
						if (fcnt_reg + 2'h1 >= flush_n)
							st_reg <= HRX_ST_BODY;
					end
				end
				HRX_ST_BODY: begin
					if (take && rx_end) begin
						stat_reg <= rx_status;
						st_reg   <= HRX_ST_STAT;
					end
				end
				HRX_ST_STAT:
					if (push_rdy)
						st_reg <= HRX_ST_IDLE;
				HRX_ST_DROP:
					if (take && rx_end)
						st_reg <= HRX_ST_IDLE;
				default: st_reg <= HRX_ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Frame classification
	// ----------------------------------------
	logic auto_reg, cmd_reg, rsp_reg, acc_p_reg, drop_p_reg;
	wire  decide = (st_reg == HRX_ST_ADDR) && m_recog && addr_full;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			auto_reg   <= 1'b0;
			cmd_reg    <= 1'b0;
			rsp_reg    <= 1'b0;
			acc_p_reg  <= 1'b0;
			drop_p_reg <= 1'b0;
		end else begin
			acc_p_reg  <= decide && accept;
			drop_p_reg <= decide && !accept;
			if (decide) begin
				auto_reg <= accept && auto_hit;
				cmd_reg  <= accept && !two_reg && !m_addr1 && lo_one;
				rsp_reg  <= accept && !two_reg && !m_addr1 && !lo_one && lo_two;
			end
		end
	end
	assign frame_auto     = auto_reg;
	assign frame_command  = cmd_reg;
	assign frame_response = rsp_reg;
	assign frame_accepted = acc_p_reg;
	assign frame_dropped  = drop_p_reg;

	// ----------------------------------------
	// Receive FIFO
	// ----------------------------------------
	hrx_fifo #(
		.WIDTH(`HRX_FIFO_WIDTH),
		.DEPTH(`HRX_FIFO_DEPTH)
	) u_fifo (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.in_valid (push_v),
		.in_ready (push_rdy),
		.in_data  (push_d),
		.out_valid(fifo_valid),
		.out_ready(fifo_ready),
		.out_data (fifo_data)
	);

endmodule

`default_nettype wire

// *** hdl/hrx_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none

module hrx_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_reg;
	logic [AW-1:0]    rd_reg;
	logic [AW:0]      cnt_reg;
	wire              push;
	wire              pop;

	assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_reg[rd_reg];

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			if (push)
				wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
			if (pop)
				rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
			cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// Storage needs no reset; reads are gated by out_valid
	always_ff @(posedge ref_clk) begin
		if (push)
			mem_reg[wr_reg] <= in_data;
	end

endmodule

`default_nettype wire

// *** hdl/hrx_params.svh ***
`ifndef HRX_PARAMS_SVH
`define HRX_PARAMS_SVH

// Serial engine selection
`define HRX_SEL_HDLC      2'h0
`define HRX_SEL_BISYNC    2'h2
`define HRX_SEL_ASYNC     2'h3

// Submode field codes
`define HRX_MDS_AUTO      2'h0
`define HRX_MDS_ADDR2     2'h1
`define HRX_MDS_ADDR10    2'h2
`define HRX_MDS_XTRANS    2'h3

// PPP mode field codes
`define HRX_PPP_NONE      2'h0
`define HRX_PPP_OCTET     2'h1
`define HRX_PPP_ASYNC     2'h2
`define HRX_PPP_BITSYNC   2'h3

// Fixed group addresses and command/response bit
`define HRX_GROUP_A       8'hFE
`define HRX_GROUP_B       8'hFC
`define HRX_CR_BIT        1

// Storage
`define HRX_FIFO_WIDTH    8
`define HRX_FIFO_DEPTH    8
`define HRX_FRAME_DEPTH   8'h40
`define HRX_MASK_RESET    8'h00

`endif

// *** hdl/hrx_pkg.sv ***
`default_nettype none
package hrx_pkg;

	typedef enum logic [3:0] {
		HRX_MODE_OFF     = 4'h0,
		HRX_MODE_AUTO    = 4'h1,
		HRX_MODE_ADDR2   = 4'h2,
		HRX_MODE_ADDR1   = 4'h3,
		HRX_MODE_ADDR0   = 4'h4,
		HRX_MODE_SS7     = 4'h5,
		HRX_MODE_PPP_BIT = 4'h6,
		HRX_MODE_PPP_OCT = 4'h7,
		HRX_MODE_PPP_ASY = 4'h8,
		HRX_MODE_XTRANS  = 4'h9
	} hrx_mode_t;

	typedef enum logic [2:0] {
		HRX_ST_IDLE  = 3'h0,
		HRX_ST_ADDR  = 3'h1,
		HRX_ST_BODY  = 3'h2,
		HRX_ST_DROP  = 3'h3,
		HRX_ST_FLUSH = 3'h4,
		HRX_ST_STAT  = 3'h5
	} hrx_state_t;

endpackage

`default_nettype wire

// *** tb/hrx_filter_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module hrx_filter_chk
	import hrx_pkg::*;
(
	// Clock and reset
	input wire logic       ref_clk,
	input wire logic       rst_n,
	// Mode inputs
	input wire logic [1:0] serial_engine_select,
	input wire logic [1:0] hdlc_submode_field,
	input wire logic       address_width_bit,
	input wire logic [1:0] ppp_mode_field,
	input wire logic       signalling7_enable,
	// Outputs watched
	input wire logic       fifo_valid,
	input wire logic       fifo_ready,
	input wire logic [7:0] fifo_data,
	input wire hrx_mode_t  mode_now,
	input wire logic       hdlc_engine_on,
	input wire logic       async_engine_on,
	input wire logic       bisync_engine_on,
	input wire logic       frame_auto,
	input wire logic       frame_command,
	input wire logic       frame_response,
	input wire logic       frame_accepted,
	input wire logic       frame_dropped
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	wire logic hs = serial_engine_select == 2'h0;
	wire logic m2 = hs && hdlc_submode_field == 2'h2 && !address_width_bit;

	engine_sel_a: assert property (
		hdlc_engine_on == hs && async_engine_on == (serial_engine_select == 2'h3)
		&& bisync_engine_on == (serial_engine_select == 2'h2)) else $error("engine select wrong");
	auto_dec_a: assert property (hs && hdlc_submode_field == 2'h0 |-> mode_now == HRX_MODE_AUTO)
		else $error("automode decode wrong");
	addr2_dec_a: assert property (hs && hdlc_submode_field == 2'h1 |-> mode_now == HRX_MODE_ADDR2)
		else $error("mode 2 decode wrong");
	addr1_dec_a: assert property (
		hs && hdlc_submode_field == 2'h2 && address_width_bit |-> mode_now == HRX_MODE_ADDR1)
		else $error("mode 1 decode wrong");
	addr0_dec_a: assert property (
		m2 && ppp_mode_field == 2'h0 && !signalling7_enable |-> mode_now == HRX_MODE_ADDR0)
		else $error("mode 0 decode wrong");
	ss7_dec_a: assert property (m2 && ppp_mode_field == 2'h0 && signalling7_enable |-> mode_now == HRX_MODE_SS7)
		else $error("ss7 decode wrong");
	ppp_dec_a: assert property (m2 && ppp_mode_field == 2'h3 |-> mode_now == HRX_MODE_PPP_BIT)
		else $error("ppp decode wrong");
	xtrans_dec_a: assert property (
		hs && hdlc_submode_field == 2'h3 && address_width_bit |-> mode_now == HRX_MODE_XTRANS)
		else $error("transparent decode wrong");
	verdict_excl_a: assert property (!(frame_accepted && frame_dropped))
		else $error("accept and drop together");
	accept_pulse_a: assert property (frame_accepted |=> !frame_accepted)
		else $error("accept pulse too long");
	cmd_resp_a: assert property (!(frame_command && frame_response))
		else $error("command and response together");
	fifo_hold_a: assert property (fifo_valid && !fifo_ready |=> fifo_valid && $stable(fifo_data))
		else $error("fifo output not held");

	cover property (frame_accepted && frame_auto);
	cover property (frame_dropped);
	cover property (fifo_valid && !fifo_ready);
endmodule
bind hrx_addr_filter hrx_filter_chk u_chk (.ref_clk, .rst_n, .serial_engine_select, .hdlc_submode_field,
	.address_width_bit, .ppp_mode_field, .signalling7_enable, .fifo_valid, .fifo_ready, .fifo_data, .mode_now,
	.hdlc_engine_on, .async_engine_on, .bisync_engine_on, .frame_auto, .frame_command, .frame_response,
	.frame_accepted, .frame_dropped);
`default_nettype wire

// *** tb/hrx_remote_station.sv ***
`timescale 1ns/1ps
`default_nettype none
module hrx_remote_station (
	// Clock
	input  wire logic       ref_clk,
	// Octet stream
	output logic            rx_valid,
	input  wire logic       rx_ready,
	output logic      [7:0] rx_data,
	output logic            rx_end,
	output logic      [7:0] rx_status
);
	int gap = 0;
	initial begin
		rx_valid = 1'b0;
		rx_end = 1'b0;
		rx_data = 8'h00;
		rx_status = 8'h00;
	end
	// Released lines show inverted data so a stale octet never reads as valid
	task automatic beat(input logic [7:0] d, input logic e);
		repeat (gap) @(posedge ref_clk);
		@(posedge ref_clk);
		#1;
		rx_valid = 1'b1;
		rx_end = e;
		rx_data = d;
		rx_status = d;
		do @(posedge ref_clk); while (rx_ready !== 1'b1);
		#1;
		rx_valid = 1'b0;
		rx_end = 1'b0;
		rx_data = ~d;
		rx_status = ~d;
	endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench
	import hrx_pkg::*;
;
	logic       ref_clk, rst_n, rx_valid, rx_ready, rx_end, fifo_valid, fwd, ri, w, ss7, stall;
	logic [1:0] sel, sub, ppp;
	logic [7:0] hc1, hc2, lc1, lc2, lm1, rx_data, rx_status, fifo_data;
	hrx_mode_t  mode_now;
	logic       eng_h, eng_a, eng_b, f_auto, f_cmd, f_rsp, f_acc, f_drop, s_acc, s_drop, refused;
	logic [7:0] tx[$], exp[$], got[$];
	int         err_count = 0;
	int         n_tests = 0;

	hrx_remote_station u_rem (.ref_clk, .rx_valid, .rx_ready, .rx_data, .rx_end, .rx_status);
	hrx_addr_filter u_dut (.ref_clk, .rst_n, .serial_engine_select(sel), .hdlc_submode_field(sub),
		.address_width_bit(w), .ppp_mode_field(ppp), .signalling7_enable(ss7), .address_forward_enable(fwd),
		.high_compare_one(hc1), .high_compare_two(hc2), .low_compare_one(lc1), .low_compare_two(lc2),
		.response_indication_bit(ri), .high_mask_one(8'h00), .high_mask_two(8'h00), .low_mask_one(lm1),
		.low_mask_two(8'h00), .rx_valid, .rx_ready, .rx_data, .rx_end, .rx_status, .fifo_valid,
		.fifo_ready(!stall), .fifo_data, .mode_now, .hdlc_engine_on(eng_h), .async_engine_on(eng_a),
		.bisync_engine_on(eng_b), .frame_auto(f_auto), .frame_command(f_cmd), .frame_response(f_rsp),
		.frame_accepted(f_acc), .frame_dropped(f_drop));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		if (fifo_valid && !stall) got.push_back(fifo_data);
		if (f_acc) s_acc <= 1'b1;
		if (f_drop) s_drop <= 1'b1;
		if (rx_valid && !rx_ready) refused <= 1'b1;
	end

	task chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task stop_test;
		$display("Checks %0d, errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Code packs select, submode, width, ppp field, ss7 enable
	task dec(input logic [7:0] k, input hrx_mode_t m);
		@(posedge ref_clk);
		#1;
		{sel, sub, w, ppp, ss7} = k;
		#2;
		chk({7'h00, eng_h}, {7'h00, k[7:6] == 2'h0});
		chk({7'h00, eng_a}, {7'h00, k[7:6] == 2'h3});
		chk({7'h00, eng_b}, {7'h00, k[7:6] == 2'h2});
		if (k[7:6] == 2'h0) chk({4'h0, mode_now}, {4'h0, m});
	endtask

	// Sends tx as one frame; with acc set, octets from skip on plus status are expected, else none
	task run(input int skip, input logic acc);
		int i;
		exp = {};
		for (i = skip; acc && i < tx.size(); i++) exp.push_back(tx[i]);
		if (acc) exp.push_back(8'h5A);
		@(posedge ref_clk);
		#1;
		got = {};
		s_acc = 1'b0;
		s_drop = 1'b0;
		refused = 1'b0;
		fork
			begin
				foreach (tx[j]) u_rem.beat(tx[j], 1'b0);
				u_rem.beat(8'h5A, 1'b1);
			end
			begin
				repeat (30) @(posedge ref_clk);
				#1 stall = 1'b0;
			end
		join
		for (i = 0; i < 60 && got.size() < exp.size(); i++) @(posedge ref_clk);
		repeat (5) @(posedge ref_clk);
		#1;
		chk(8'(got.size()), 8'(exp.size()));
		foreach (exp[k]) if (k < got.size()) chk(got[k], exp[k]);
		if (mode_now != HRX_MODE_ADDR0) begin
			chk({7'h00, s_acc}, {7'h00, acc});
			chk({7'h00, s_drop}, {7'h00, !acc});
		end
	endtask

	initial begin
		rst_n = 1'b0;
		stall = 1'b0;
		fwd = 1'b0;
		ri = 1'b1;
		{sel, sub, w, ppp, ss7} = 8'h08;
		hc1 = 8'h40;
		hc2 = 8'h50;
		lc1 = 8'h21;
		lc2 = 8'h33;
		lm1 = 8'h00;
		repeat (12) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		#1;
		chk({7'h00, rx_ready}, 8'h01);
		chk({7'h00, fifo_valid}, 8'h00);
		dec(8'hC0, HRX_MODE_OFF);
		dec(8'h80, HRX_MODE_OFF);
		dec(8'h10, HRX_MODE_ADDR2);
		dec(8'h28, HRX_MODE_ADDR1);
		dec(8'h20, HRX_MODE_ADDR0);
		dec(8'h21, HRX_MODE_SS7);
		dec(8'h26, HRX_MODE_PPP_BIT);
		dec(8'h22, HRX_MODE_PPP_OCT);
		dec(8'h24, HRX_MODE_PPP_ASY);
		dec(8'h38, HRX_MODE_XTRANS);
		dec(8'h30, HRX_MODE_OFF);
		dec(8'h08, HRX_MODE_AUTO);
		tx = '{8'h42, 8'h21, 8'h11, 8'hC3};
		run(2, 1'b1);
		chk({7'h00, f_auto}, 8'h01);
		u_rem.gap = 3;
		tx = '{8'hFC, 8'h33, 8'h11};
		run(2, 1'b1);
		chk({7'h00, f_auto}, 8'h00);
		u_rem.gap = 0;
		tx = '{8'h50, 8'h99, 8'h11};
		run(2, 1'b0);
		lm1 = 8'h0F;
		tx = '{8'h50, 8'h2E, 8'h11};
		run(2, 1'b1);
		lm1 = 8'h00;
		dec(8'h00, HRX_MODE_AUTO);
		tx = '{8'h33, 8'h11, 8'h77};
		run(1, 1'b1);
		chk({7'h00, f_rsp}, 8'h01);
		chk({7'h00, f_cmd}, 8'h00);
		dec(8'h18, HRX_MODE_ADDR2);
		fwd = 1'b1;
		tx = '{8'h50, 8'h33, 8'h11};
		run(0, 1'b1);
		fwd = 1'b0;
		dec(8'h28, HRX_MODE_ADDR1);
		tx = '{8'h50, 8'h99, 8'h11};
		run(1, 1'b1);
		tx = '{8'h77, 8'h11};
		run(1, 1'b0);
		dec(8'h20, HRX_MODE_ADDR0);
		tx = {};
		for (int i = 0; i < 10; i++) tx.push_back(8'hB0 + 8'(i));
		stall = 1'b1;
		run(0, 1'b1);
		chk({7'h00, refused}, 8'h01);
		stop_test();
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		err_count++;
		$display("Error %0t: watchdog expired", $time);
		stop_test();
	end
endmodule
`default_nettype wire
